// file: design/sbc_pkg.sv
package sbc_pkg;

   // Clock rate and derived cycle counts.
   localparam int unsigned CLK_MHZ          = 100;
   localparam int unsigned CYCLE_LIMIT_NS   = 8000;
   localparam int unsigned CYCLE_LIMIT_CYC  = CYCLE_LIMIT_NS * CLK_MHZ / 1000;
   localparam int unsigned REFRESH_NS       = 15000;
   localparam int unsigned REFRESH_CYC      = REFRESH_NS * CLK_MHZ / 1000;
   localparam int unsigned TMR_W            = 12;
   localparam int unsigned RF_W             = 12;
   localparam logic [TMR_W-1:0] TMR_RST     = 12'h000;
   localparam logic [RF_W-1:0]  RF_RST      = 12'h000;

   // Bus and instruction geometry.
   localparam int unsigned ADDR_W           = 24;
   localparam int unsigned DEVNO_W          = 11;
   localparam logic [DEVNO_W-1:0] DEV_TERM1 = 11'h0c0;
   localparam logic [DEVNO_W-1:0] DEV_RTC   = 11'h008;
   localparam logic [3:0] TIMEOUT_LEVEL     = 4'he;
   localparam logic [1:0] RING_MIN          = 2'h2;
   localparam int unsigned UADDR_W          = 8;
   localparam logic [UADDR_W-1:0] UA_ERROR  = 8'hff;
   localparam logic [UADDR_W-1:0] UA_XCHG   = 8'h40;

   // Grant owner encoding.
   typedef enum logic [1:0] {
      SBC_OWN_NONE = 2'h0,
      SBC_OWN_CPU  = 2'h1,
      SBC_OWN_DMA  = 2'h2,
      SBC_OWN_REF  = 2'h3
   } sbc_owner_e;

   // Arbiter states, Gray along idle, grant, hold, release.
   typedef enum logic [1:0] {
      SBC_IDLE  = 2'h0,
      SBC_GRANT = 2'h1,
      SBC_HOLD  = 2'h3,
      SBC_REL   = 2'h2
   } sbc_state_e;

endpackage

// file: design/sbc_priv_gate.sv
`timescale 1ns/1ps
// Checks privileged instructions and flags exchanges addressed to on-module devices.
module sbc_priv_gate (
   input  wire logic                             mmu_enable,
   input  wire logic [1:0]                       ring_level,
   input  wire logic                             priv_instr,
   input  wire logic                             io_exchange_instr,
   input  wire logic                             io_exchange_long_instr,
   input  wire logic [sbc_pkg::DEVNO_W-1:0]      io_device_number,
   input  wire logic [sbc_pkg::UADDR_W-1:0]      map_addr_in,
   output logic                                  privileged_op_permit,
   output logic [sbc_pkg::UADDR_W-1:0]           map_addr_out,
   output logic                                  io_local_device
);

   logic is_priv;

   // Permit is given unless memory management is on and the ring is too low.
   always_comb begin
      is_priv = priv_instr | io_exchange_instr | io_exchange_long_instr;
      privileged_op_permit = ~mmu_enable | (ring_level >= sbc_pkg::RING_MIN);
      if (is_priv && !privileged_op_permit) begin
         map_addr_out = sbc_pkg::UA_ERROR;
      end else if (io_exchange_instr || io_exchange_long_instr) begin
         map_addr_out = sbc_pkg::UA_XCHG;
      end else begin
         map_addr_out = map_addr_in;
      end
      io_local_device = (io_exchange_instr | io_exchange_long_instr)
                        & ((io_device_number == sbc_pkg::DEV_TERM1) | (io_device_number == sbc_pkg::DEV_RTC));
   end

endmodule

// file: design/sbc_bus_control.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module sbc_bus_control (
   input  wire logic                             mclk,
   input  wire logic                             reset,
   input  wire logic                             cpu_bus_request,
   input  wire logic                             dma_bus_request,
   input  wire logic                             transfer_done_signal,
   input  wire logic                             mmu_enable,
   input  wire logic [1:0]                       ring_level,
   input  wire logic                             priv_instr,
   input  wire logic                             io_exchange_instr,
   input  wire logic                             io_exchange_long_instr,
   input  wire logic [sbc_pkg::DEVNO_W-1:0]      io_device_number,
   input  wire logic [sbc_pkg::UADDR_W-1:0]      map_addr_in,
   output logic                                  cpu_grant,
   output logic                                  dma_grant,
   output logic                                  refresh_grant,
   output logic                                  bus_busy,
   output logic                                  timeout_irq,
   output logic [3:0]                            timeout_irq_level,
   output logic                                  refresh_pending,
   output logic                                  privileged_op_permit,
   output logic [sbc_pkg::UADDR_W-1:0]           map_addr_out,
   output logic                                  io_local_device
);

   // Arbiter state, the owner of the cycle in flight and the class that had the last cycle.
   sbc_pkg::sbc_state_e                  state_r;
   sbc_pkg::sbc_state_e                  state_nxt;
   sbc_pkg::sbc_owner_e                  owner_r;
   sbc_pkg::sbc_owner_e                  owner_nxt;
   logic                                 last_dma_r;
   logic                                 last_dma_nxt;

   // Cycle timer and the one-clock abort interrupt.
   logic [sbc_pkg::TMR_W-1:0]            tmr_r;
   logic [sbc_pkg::TMR_W-1:0]            tmr_nxt;
   logic                                 irq_r;
   logic                                 irq_nxt;

   // Refresh period divider and the pending refresh request.
   logic [sbc_pkg::RF_W-1:0]             rf_cnt_r;
   logic [sbc_pkg::RF_W-1:0]             rf_cnt_nxt;
   logic                                 refresh_request_r;
   logic                                 refresh_request_nxt;

   // Decoded conditions shared by the processes below.
   logic                                 rf_tick;
   logic                                 rf_served;
   logic                                 timed_out;

   //////////////////////////////////////////////////////////////////////////////
   // Returns the next owner for the pending requests, honouring class toggling.
   function automatic sbc_pkg::sbc_owner_e pick_owner(input logic cpu_rq, input logic dma_rq,
                                                      input logic ref_rq, input logic last_dma);
      logic dma_class;
      // Refresh outranks DMA inside its class, and on a tie the class that did not have the last cycle goes first.
      dma_class = dma_rq | ref_rq;
      if (dma_class && (!cpu_rq || !last_dma)) begin
         pick_owner = ref_rq ? sbc_pkg::SBC_OWN_REF : sbc_pkg::SBC_OWN_DMA;
      end else if (cpu_rq) begin
         pick_owner = sbc_pkg::SBC_OWN_CPU;
      end else begin
         pick_owner = sbc_pkg::SBC_OWN_NONE;
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // Advances the cycle timer by one clock; the limit lies far below its top value,
   // so it never wraps inside a cycle.
   function automatic logic [sbc_pkg::TMR_W-1:0] tmr_step(input logic [sbc_pkg::TMR_W-1:0] t);
      tmr_step = t + 1'b1;
   endfunction

   // True while a cycle is in flight and belongs to the given requestor.
   function automatic logic owned_by(input sbc_pkg::sbc_state_e st, input sbc_pkg::sbc_owner_e own,
                                     input sbc_pkg::sbc_owner_e who);
      owned_by = (st != sbc_pkg::SBC_IDLE) && (own == who);
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // Periodic refresh request, held until a refresh cycle is granted.
   // The divider runs freely from reset, so the first request comes one period after it.
   always_comb begin
      rf_tick    = (rf_cnt_r == sbc_pkg::RF_W'(sbc_pkg::REFRESH_CYC - 1));
      rf_cnt_nxt = rf_tick ? sbc_pkg::RF_RST : rf_cnt_r + 1'b1;
      rf_served  = (state_r == sbc_pkg::SBC_GRANT) && (owner_r == sbc_pkg::SBC_OWN_REF);
      // A new tick wins over the clear by the serving grant.
      refresh_request_nxt = rf_tick | (refresh_request_r & ~rf_served);
   end

   // Registers the refresh timer.
   always_ff @(posedge mclk) begin
      if (reset) begin
         rf_cnt_r          <= sbc_pkg::RF_RST;
         refresh_request_r <= 1'b0;
      end else begin
         rf_cnt_r          <= rf_cnt_nxt;
         refresh_request_r <= refresh_request_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Arbiter and cycle timer; the data exchange itself is left to the user.
   // Every branch starts from the held values, irq_nxt from zero, so a state lists only what it changes.
   always_comb begin
      state_nxt    = state_r;
      owner_nxt    = owner_r;
      last_dma_nxt = last_dma_r;
      tmr_nxt      = tmr_r;
      irq_nxt      = 1'b0;
      timed_out    = (tmr_r >= sbc_pkg::TMR_W'(sbc_pkg::CYCLE_LIMIT_CYC - 1));
      unique case (state_r)
         sbc_pkg::SBC_IDLE: begin
            // Only an idle bus is arbitrated, and the timer waits at zero.
            owner_nxt = pick_owner(cpu_bus_request, dma_bus_request, refresh_request_r, last_dma_r);
            tmr_nxt   = sbc_pkg::TMR_RST;
            if (owner_nxt != sbc_pkg::SBC_OWN_NONE) begin
               state_nxt    = sbc_pkg::SBC_GRANT;
               last_dma_nxt = (owner_nxt != sbc_pkg::SBC_OWN_CPU);
            end
         end
         sbc_pkg::SBC_GRANT: begin
            // Grant is held without preemption while the user runs its phases.
            state_nxt = sbc_pkg::SBC_HOLD;
            tmr_nxt   = tmr_step(tmr_r);
         end
         sbc_pkg::SBC_HOLD: begin
            // Done ends the word; the limit aborts it when done never comes.
            tmr_nxt = tmr_step(tmr_r);
            if (transfer_done_signal) begin
               state_nxt = sbc_pkg::SBC_REL;
               tmr_nxt   = sbc_pkg::TMR_RST;
            end else if (timed_out) begin
               state_nxt = sbc_pkg::SBC_IDLE;
               owner_nxt = sbc_pkg::SBC_OWN_NONE;
               irq_nxt   = 1'b1;
               tmr_nxt   = sbc_pkg::TMR_RST;
            end
         end
         sbc_pkg::SBC_REL: begin
            // Wait for the accessed device to drop transfer done before rearbitrating.
            // A done held too long meets the same limit, so a stuck device cannot hang the bus.
            if (!transfer_done_signal) begin
               state_nxt = sbc_pkg::SBC_IDLE;
               owner_nxt = sbc_pkg::SBC_OWN_NONE;
            end else if (timed_out) begin
               state_nxt = sbc_pkg::SBC_IDLE;
               owner_nxt = sbc_pkg::SBC_OWN_NONE;
               irq_nxt   = 1'b1;
            end else begin
               tmr_nxt = tmr_step(tmr_r);
            end
         end
      endcase
   end

   // Registers the arbiter state.
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r    <= sbc_pkg::SBC_IDLE;
         owner_r    <= sbc_pkg::SBC_OWN_NONE;
         last_dma_r <= 1'b0;
         tmr_r      <= sbc_pkg::TMR_RST;
         irq_r      <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         owner_r    <= owner_nxt;
         last_dma_r <= last_dma_nxt;
         tmr_r      <= tmr_nxt;
         irq_r      <= irq_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Grants are levels while the cycle is owned; refresh needs no data phase.
   assign bus_busy          = (state_r != sbc_pkg::SBC_IDLE);
   assign cpu_grant         = owned_by(state_r, owner_r, sbc_pkg::SBC_OWN_CPU);
   assign dma_grant         = owned_by(state_r, owner_r, sbc_pkg::SBC_OWN_DMA);
   assign refresh_grant     = owned_by(state_r, owner_r, sbc_pkg::SBC_OWN_REF);
   assign timeout_irq       = irq_r;
   assign timeout_irq_level = sbc_pkg::TIMEOUT_LEVEL;
   assign refresh_pending   = refresh_request_r;

   // Privilege check and on-module device decode.
   // It is pure decode, so the microcode sees its answer in the same clock.
   sbc_priv_gate sbc_priv_gate_i (
      .mmu_enable             (mmu_enable),
      .ring_level             (ring_level),
      .priv_instr             (priv_instr),
      .io_exchange_instr      (io_exchange_instr),
      .io_exchange_long_instr (io_exchange_long_instr),
      .io_device_number       (io_device_number),
      .map_addr_in            (map_addr_in),
      .privileged_op_permit   (privileged_op_permit),
      .map_addr_out           (map_addr_out),
      .io_local_device        (io_local_device)
   );

endmodule

// file: tb/sbc_dev_model.sv
`timescale 1ns/1ps
// Granted user and accessed device: the user runs an address phase, then a data phase,
// and the device ends each granted cycle, unless muted, with a one-cycle done pulse.
module sbc_dev_model #(
   parameter int unsigned DELAY       = 3,
   parameter logic [3:0]  IDENT_LEVEL = 4'hc
) (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic grant,
   input  wire logic refresh,
   input  wire logic mute,
   output logic      done
);
   logic [11:0] cnt_r;
   logic [23:0] addr_r;
   logic        addr_seen_r;
   logic        level_ok;
   logic        address_present_strobe;
   logic        start_of_data;
   logic [23:0] muxed_addr_data_lines;
   // The user strobes the address in the first granted clock, then starts the data phase.
   assign address_present_strobe = grant && !refresh && (cnt_r == 12'h000);
   assign muxed_addr_data_lines  = address_present_strobe ? {20'h00001, IDENT_LEVEL} : 24'h000000;
   assign start_of_data          = grant && !refresh && (cnt_r != 12'h000);
   assign level_ok               = (addr_r[3:0] >= 4'ha) && (addr_r[3:0] <= 4'hd);
   // Counts granted clocks and acknowledges after DELAY; mute leaves the cycle hanging.
   always @(posedge mclk) begin
      if (reset || !grant) begin
         cnt_r       <= 12'h000;
         addr_r      <= 24'h000000;
         addr_seen_r <= 1'b0;
         done        <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 12'h001;
         if (address_present_strobe) begin
            addr_r      <= muxed_addr_data_lines;
            addr_seen_r <= 1'b1;
         end
         // A data cycle is answered only after a strobed address; refresh needs none.
         done <= (cnt_r == 12'(DELAY)) && !mute
                 && (refresh || (addr_seen_r && start_of_data && level_ok));
      end
   end
endmodule

// file: tb/sbc_bus_control_sva.sv
`timescale 1ns/1ps
// Watches arbitration, cycle length and privilege gating at the unit's ports.
module sbc_bus_control_sva (
   input wire logic                        mclk,
   input wire logic                        reset,
   input wire logic                        cpu_bus_request,
   input wire logic                        dma_bus_request,
   input wire logic                        transfer_done_signal,
   input wire logic                        mmu_enable,
   input wire logic                        priv_instr,
   input wire logic                        io_exchange_instr,
   input wire logic                        io_exchange_long_instr,
   input wire logic [1:0]                  ring_level,
   input wire logic [sbc_pkg::UADDR_W-1:0] map_addr_in,
   input wire logic [sbc_pkg::UADDR_W-1:0] map_addr_out,
   input wire logic                        cpu_grant,
   input wire logic                        dma_grant,
   input wire logic                        refresh_grant,
   input wire logic                        bus_busy,
   input wire logic                        timeout_irq,
   input wire logic                        refresh_pending,
   input wire logic                        privileged_op_permit,
   input wire logic [3:0]                  timeout_irq_level
);
   logic [11:0] cnt_r;
   logic        last_cpu_r;
   logic        done_seen_r;
   logic        xchg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   assign xchg = io_exchange_instr | io_exchange_long_instr;
   // Times the busy run up to done, notes whether done came, and who owned the last cycle.
   always_ff @(posedge mclk) begin
      cnt_r       <= (reset || !bus_busy || transfer_done_signal) ? 12'h000 : cnt_r + 12'h001;
      done_seen_r <= (reset || !bus_busy) ? 1'b0 : done_seen_r | transfer_done_signal;
      last_cpu_r <= reset ? 1'b1 : cpu_grant ? 1'b1 : (dma_grant | refresh_grant) ? 1'b0 : last_cpu_r;
   end
   property p_one; $onehot0({cpu_grant, dma_grant, refresh_grant}) && bus_busy == (cpu_grant | dma_grant | refresh_grant); endproperty
   a_one: assert property (p_one) else $error("grant owners inconsistent");
   property p_take; !bus_busy && (cpu_bus_request || dma_bus_request || refresh_pending) |=> bus_busy; endproperty
   a_take: assert property (p_take) else $error("idle request not granted");
   property p_keep; bus_busy && $past(bus_busy) |-> $stable({cpu_grant, dma_grant, refresh_grant}); endproperty
   a_keep: assert property (p_keep) else $error("owner changed in a cycle");
   property p_ref; !bus_busy && refresh_pending && !cpu_bus_request |=> refresh_grant; endproperty
   a_ref: assert property (p_ref) else $error("refresh lost to dma");
   property p_tog; !bus_busy && cpu_bus_request && (dma_bus_request || refresh_pending) |=> cpu_grant != $past(last_cpu_r); endproperty
   a_tog: assert property (p_tog) else $error("class priority did not toggle");
   property p_lim; bus_busy |-> cnt_r <= 12'h31f; endproperty
   a_lim: assert property (p_lim) else $error("cycle ran past the limit");
   property p_irq; $fell(bus_busy) |-> timeout_irq == (!done_seen_r || $past(transfer_done_signal)); endproperty
   a_irq: assert property (p_irq) else $error("abort and interrupt disagree");
   property p_lvl; timeout_irq |-> $fell(bus_busy) && timeout_irq_level == 4'he ##1 !timeout_irq; endproperty
   a_lvl: assert property (p_lvl) else $error("bad interrupt pulse or level");
   property p_prv; privileged_op_permit == (!mmu_enable || ring_level >= 2'h2); endproperty
   a_prv: assert property (p_prv) else $error("bad privilege permit");
   property p_map; map_addr_out == (!privileged_op_permit && (priv_instr || xchg) ? sbc_pkg::UA_ERROR :
      xchg ? sbc_pkg::UA_XCHG : map_addr_in); endproperty
   a_map: assert property (p_map) else $error("bad micro-address map");
   c_irq: cover property (timeout_irq);
   c_tie: cover property (!bus_busy && cpu_bus_request && dma_bus_request);
   c_ref: cover property (refresh_grant);
endmodule
bind sbc_bus_control sbc_bus_control_sva sbc_bus_control_sva_i (.mclk, .reset, .cpu_bus_request, .dma_bus_request,
   .transfer_done_signal,
   .mmu_enable, .priv_instr, .io_exchange_instr, .io_exchange_long_instr, .ring_level, .map_addr_in, .map_addr_out,
   .cpu_grant, .dma_grant, .refresh_grant, .bus_busy, .timeout_irq, .refresh_pending, .privileged_op_permit,
   .timeout_irq_level);

// file: tb/sbc_bus_control_tb.sv
`timescale 1ns/1ps
module sbc_bus_control_tb;
   logic mclk, reset, cpu_bus_request, dma_bus_request, transfer_done_signal, mmu_enable, mute, seen;
   logic priv_instr, io_exchange_instr, io_exchange_long_instr, cpu_grant, dma_grant, refresh_grant;
   logic bus_busy, timeout_irq, refresh_pending, privileged_op_permit, io_local_device, p;
   logic [1:0] ring_level;
   logic [2:0] own;
   logic [3:0] timeout_irq_level;
   logic [sbc_pkg::DEVNO_W-1:0] io_device_number;
   logic [sbc_pkg::UADDR_W-1:0] map_addr_in, map_addr_out;
   int errors, num_checks, cyc, waited;
   sbc_bus_control sbc_bus_control_i (.mclk, .reset, .cpu_bus_request, .dma_bus_request, .transfer_done_signal,
      .mmu_enable, .ring_level, .priv_instr, .io_exchange_instr, .io_exchange_long_instr, .io_device_number,
      .map_addr_in, .cpu_grant, .dma_grant, .refresh_grant, .bus_busy, .timeout_irq, .timeout_irq_level,
      .refresh_pending, .privileged_op_permit, .map_addr_out, .io_local_device);
   sbc_dev_model sbc_dev_model_i (.mclk, .reset, .grant(cpu_grant | dma_grant | refresh_grant),
      .refresh(refresh_grant), .mute, .done(transfer_done_signal));
   // Makes the 100 MHz clock; cyc counts edges since reset.
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= reset ? 0 : cyc + 1;
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Waits at falling edges for a grant, or for an idle bus, under a bound.
   task automatic wait_bus(input logic want_grant);
      waited = 0;
      own = {refresh_grant, dma_grant, cpu_grant};
      while ((want_grant ? own == 3'h0 : bus_busy !== 1'b0) && waited < 2000) begin
         @(negedge mclk);
         own = {refresh_grant, dma_grant, cpu_grant};
         waited++;
      end
      chk("bus wait", waited < 2000, 1'b1);
   endtask
   // Simultaneous requests: the processor waits out the DMA cycle.
   task automatic t_tie();
      cpu_bus_request = 1'b1;
      dma_bus_request = 1'b1;
      wait_bus(1'b1);
      chk("first owner", own, 3'h2);
      dma_bus_request = 1'b0;
      wait_bus(1'b0);
      wait_bus(1'b1);
      chk("second owner", own, 3'h1);
      cpu_bus_request = 1'b0;
      wait_bus(1'b0);
      chk("released", bus_busy, 1'b0);
   endtask
   // A device that never answers is cut off, and the bus serves again.
   task automatic t_timeout();
      mute = 1'b1;
      dma_bus_request = 1'b1;
      wait_bus(1'b1);
      dma_bus_request = 1'b0;
      wait_bus(1'b0);
      seen = timeout_irq;
      chk("cycle limit", waited >= sbc_pkg::CYCLE_LIMIT_CYC - 1 && waited <= sbc_pkg::CYCLE_LIMIT_CYC + 2, 1'b1);
      @(negedge mclk);
      chk("abort irq", seen | timeout_irq, 1'b1);
      chk("irq level", timeout_irq_level, 4'he);
      mute = 1'b0;
      cpu_bus_request = 1'b1;
      wait_bus(1'b1);
      chk("after abort", own, 3'h1);
      cpu_bus_request = 1'b0;
      wait_bus(1'b0);
   endtask
   // Periodic refresh beats a DMA request raised beside it.
   task automatic t_refresh();
      while (refresh_pending !== 1'b1 && cyc < 2000) @(negedge mclk);
      chk("refresh period", cyc > 1490 && cyc < 1510, 1'b1);
      dma_bus_request = 1'b1;
      wait_bus(1'b1);
      chk("refresh first", own, 3'h4);
      wait_bus(1'b0);
      wait_bus(1'b1);
      chk("dma next", own, 3'h2);
      dma_bus_request = 1'b0;
      wait_bus(1'b0);
   endtask
   // Every permit mode, instruction kind and device number class.
   task automatic t_priv();
      map_addr_in = 8'h25;
      for (int i = 0; i < 72; i++) begin
         @(negedge mclk);
         {ring_level, mmu_enable} = i[2:0];
         {io_exchange_long_instr, io_exchange_instr, priv_instr} = 3'h1 << (i / 8 % 3);
         io_device_number = (i < 24) ? 11'h0c0 : (i < 48) ? 11'h008 : 11'h0c1;
         #1;
         p = !i[0] || i[2];
         chk("permit", privileged_op_permit, p);
         chk("map", map_addr_out, !p ? 8'hff : priv_instr ? 8'h25 : 8'h40);
         chk("local", io_local_device, !priv_instr && i < 48);
      end
   endtask
   // Resets, runs the scenarios and ends the run.
   initial begin
      {reset, cpu_bus_request, dma_bus_request, mmu_enable, priv_instr, io_exchange_instr, io_exchange_long_instr} = 7'h40;
      {mute, ring_level, io_device_number, map_addr_in} = '0;
      repeat (12) @(negedge mclk);
      reset = 1'b0;
      t_tie();
      t_timeout();
      t_refresh();
      t_priv();
      end_of_test();
   end
   // Cuts a hang short.
   initial begin
      #100000;
      errors++;
      end_of_test();
   end
endmodule
